// file: hdl/tci_pkg.sv
package tci_pkg;

  localparam int         BUF_DEPTH    = 32;
  localparam int         BUF_AW       = 5;

  localparam logic [7:0] CH_CR        = 8'h0D;
  localparam logic [7:0] CH_LF        = 8'h0A;
  localparam logic [7:0] CH_SP        = 8'h20;
  localparam logic [7:0] CH_PROMPT    = 8'h24;
  localparam logic [7:0] CH_RUBOUT    = 8'h7F;
  localparam logic [7:0] CH_ZERO      = 8'h30;
  localparam logic [7:0] CH_SEVEN     = 8'h37;
  localparam logic [7:0] CH_A         = 8'h41;
  localparam logic [7:0] CH_Z         = 8'h5A;
  localparam logic [7:0] CH_LOAD      = 8'h4C;
  localparam logic [7:0] CH_EXAM      = 8'h45;
  localparam logic [7:0] CH_DEP       = 8'h44;
  localparam logic [7:0] CH_START     = 8'h53;

  localparam logic [15:0] WORD_STEP   = 16'h0002;
  localparam logic [2:0]  FIELD_LAST  = 3'h6;
  localparam logic [2:0]  NW_BANNER   = 3'h4;
  localparam logic [2:0]  NW_EXAM     = 3'h2;
  localparam logic [2:0]  NW_PROMPT   = 3'h0;
  localparam logic [1:0]  TAIL_LAST   = 2'h2;
  localparam logic [2:0]  IO_PAGE_SEL = 3'h7;
  localparam logic [1:0]  IO_PAGE_EXT = 2'h3;
  localparam logic [2:0]  UNIT_DEFAULT = 3'h0;
  localparam logic [2:0]  DIGIT_BITS  = 3'h3;

  typedef enum logic [9:0] {
    S_ENTRY = 10'h001,
    S_FMT   = 10'h002,
    S_PRINT = 10'h004,
    S_CMD   = 10'h008,
    S_SEP   = 10'h010,
    S_OPND  = 10'h020,
    S_DEV   = 10'h040,
    S_BOOT  = 10'h080,
    S_MEM   = 10'h100,
    S_EXIT  = 10'h200
  } tci_fsm_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_LOAD = 2'h1,
    OP_EXAM = 2'h2,
    OP_DEP  = 2'h3
  } tci_op_t;

endpackage

// file: hdl/tci_line_buf.sv
`timescale 1ns/1ps
`default_nettype none
module tci_line_buf
  import tci_pkg::*;
(
  input  wire logic              sys_clk_in,  // System clock
  input  wire logic              resetn_in,   // Async reset, active low
  input  wire logic              wr_en_in,    // Write strobe
  input  wire logic [BUF_AW-1:0] wr_addr_in,  // Write index
  input  wire logic [7:0]        wr_data_in,  // Character to store
  input  wire logic [BUF_AW-1:0] rd_addr_in,  // Read index
  output logic      [7:0]        rd_data_out  // Registered read character
);
  logic [7:0] mem [BUF_DEPTH];

  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule
`default_nettype wire

// file: hdl/tci_console.sv
// Overview of operation
// - After entry print four octal words, prompt
// - Check command letter and separator first
// - Non-octal operand character abandons entry, prompts
// - Return stores loaded address, then signals ready
// - Examine prints address and stored word
// - Deposit writes working address, then prompts
// - Start launches at working address, exits
// - First digit typed is most significant
// - Leading zeros may be omitted
// - Repeated examines advance one word each
// - Repeated deposits advance one word each
// - Alternating examine and deposit never advance
// - Reach low 28K plus the I/O page
// - Boot: two letters, optional unit, return
// - No control held after bootstrap launch
// - Boot switch aborts program, re-enters interpreter
// - Bad separator prompts, address left unchanged
// - Rubout cancels the pending entry
// - Only low 16 bits of the typed digits kept
`timescale 1ns/1ps
`default_nettype none
module tci_console
  import tci_pkg::*;
(
  input  wire logic        sys_clk_in,      // 50 MHz system clock
  input  wire logic        resetn_in,       // Async reset, active low
  input  wire logic        boot_sw_n_in,    // Boot switch pin, low while pressed
  input  wire logic        diag_pass_in,    // Processor check passed
  input  wire logic [15:0] reg_r0_in,       // Banner word 0
  input  wire logic [15:0] reg_r4_in,       // Banner word 1
  input  wire logic [15:0] reg_sp_in,       // Banner word 2
  input  wire logic [15:0] reg_pc_in,       // Banner word 3
  input  wire logic        rx_valid_in,     // Keyboard character valid
  input  wire logic [7:0]  rx_data_in,      // Keyboard character
  output logic             rx_ready_out,    // Keyboard character taken
  output logic             tx_valid_out,    // Printer character valid
  output logic      [7:0]  tx_data_out,     // Printer character
  input  wire logic        tx_ready_in,     // Printer accepts character
  output logic             mem_req_out,     // Memory cycle request
  output logic             mem_we_out,      // Memory write
  output logic      [17:0] mem_addr_out,    // Physical byte address
  output logic      [15:0] mem_wdata_out,   // Write word
  input  wire logic [15:0] mem_rdata_in,    // Read word
  input  wire logic        mem_ack_in,      // Memory cycle done
  output logic             start_out,       // Init and run pulse
  output logic      [15:0] start_addr_out,  // Run address
  output logic             boot_out,        // Bootstrap launch pulse
  output logic      [15:0] boot_dev_out,    // Two-letter device code
  output logic      [2:0]  boot_unit_out,   // Unit number
  output logic             abort_out,       // Program abort pulse
  output logic             active_out       // Interpreter owns machine
);
  typedef struct packed {
    tci_fsm_t          fsm;
    tci_fsm_t          ret;
    tci_op_t           last_op;
    logic [7:0]        cmd;
    logic [7:0]        dev_hi;
    logic [7:0]        echo_ch;
    logic              is_echo;
    logic [15:0]       operand;
    logic [15:0]       addr;
    logic [3:0][15:0]  words;
    logic [2:0]        nw;
    logic [2:0]        fword;
    logic [2:0]        fpos;
    logic [1:0]        tail;
    logic [BUF_AW-1:0] widx;
    logic [BUF_AW-1:0] ridx;
    logic              fetched;
    logic              mem_req;
    logic              mem_we;
    logic [17:0]       mem_addr;
    logic [15:0]       mem_wdata;
    logic              start;
    logic              boot;
    logic              abort;
    logic [15:0]       start_addr;
    logic [15:0]       boot_dev;
    logic [2:0]        boot_unit;
    logic              bsync1;
    logic              bsync2;
    logic              bprev;
    logic              unit_seen;
  } tci_regs_t;

  tci_regs_t  st;
  tci_regs_t  next_st;
  logic       rx_fire;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [15:0] adv_addr;

  function automatic logic is_oct(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CH_SEVEN);
  endfunction

  function automatic logic is_alpha(input logic [7:0] c);
    return (c >= CH_A) && (c <= CH_Z);
  endfunction

  function automatic logic [7:0] oct_char(input logic [15:0] w, input logic [2:0] p);
    logic [4:0]  sh;
    logic [17:0] ext;
    sh  = {2'h0, p - 3'h1} * {2'h0, DIGIT_BITS};
    ext = {2'h0, w} << sh;
    return CH_ZERO | {5'h00, ext[17:15]};
  endfunction

  // Working address after auto-advance; only a repeat of the same op moves on
  function automatic logic [15:0] next_addr(input tci_regs_t s, input tci_op_t op);
    return (s.last_op == op) ? s.addr + WORD_STEP : s.addr;
  endfunction

  // Upper 8K of the 16-bit space is steered onto the I/O page
  function automatic logic [17:0] map_addr(input logic [15:0] a);
    return (a[15:13] == IO_PAGE_SEL) ? {IO_PAGE_EXT, a} : {2'h0, a};
  endfunction

  function automatic tci_regs_t start_line(input tci_regs_t s, input logic [2:0] nw,
                                           input logic echo, input logic [7:0] ch,
                                           input tci_fsm_t ret);
    tci_regs_t r;
    r         = s;
    r.nw      = nw;
    r.is_echo = echo;
    r.echo_ch = ch;
    r.ret     = ret;
    r.fword   = 3'h0;
    r.fpos    = 3'h0;
    r.tail    = 2'h0;
    r.widx    = '0;
    r.ridx    = '0;
    r.fetched = 1'b0;
    r.fsm     = S_FMT;
    return r;
  endfunction

  function automatic tci_regs_t prompt(input tci_regs_t s);
    return start_line(s, NW_PROMPT, 1'b0, CH_SP, S_CMD);
  endfunction

  tci_line_buf u_buf (
    .sys_clk_in  (sys_clk_in),
    .resetn_in   (resetn_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (st.widx),
    .wr_data_in  (wr_data),
    .rd_addr_in  (st.ridx),
    .rd_data_out (tx_data_out)
  );

  assign rx_ready_out   = (st.fsm == S_CMD) || (st.fsm == S_SEP) || (st.fsm == S_OPND) ||
                          (st.fsm == S_DEV) || (st.fsm == S_BOOT);
  assign rx_fire        = rx_valid_in && rx_ready_out;
  assign tx_valid_out   = (st.fsm == S_PRINT) && st.fetched;
  assign mem_req_out    = st.mem_req;
  assign mem_we_out     = st.mem_we;
  assign mem_addr_out   = st.mem_addr;
  assign mem_wdata_out  = st.mem_wdata;
  assign start_out      = st.start;
  assign start_addr_out = st.start_addr;
  assign boot_out       = st.boot;
  assign boot_dev_out   = st.boot_dev;
  assign boot_unit_out  = st.boot_unit;
  assign abort_out      = st.abort;
  assign active_out     = (st.fsm != S_EXIT);

  // Line character for the current format step
  always_comb begin
    if (st.is_echo) begin
      wr_data = st.echo_ch;
    end else if (st.fword < st.nw) begin
      wr_data = (st.fpos == 3'h0) ? CH_SP : oct_char(st.words[st.fword[1:0]], st.fpos);
    end else begin
      case (st.tail)
        2'h0:    wr_data = CH_CR;
        2'h1:    wr_data = CH_LF;
        default: wr_data = CH_PROMPT;
      endcase
    end
  end

  always_comb begin
    next_st        = st;
    next_st.bsync1 = boot_sw_n_in;
    next_st.bsync2 = st.bsync1;
    next_st.bprev  = st.bsync2;
    next_st.start  = 1'b0;
    next_st.boot   = 1'b0;
    next_st.abort  = 1'b0;
    wr_en          = 1'b0;
    adv_addr       = st.addr;
    case (st.fsm)
      S_ENTRY: begin
        if (diag_pass_in) begin
          next_st.words = {reg_pc_in, reg_sp_in, reg_r4_in, reg_r0_in};
          next_st = start_line(next_st, NW_BANNER, 1'b0, CH_SP, S_CMD);
        end
      end
      S_FMT: begin
        wr_en        = 1'b1;
        next_st.widx = st.widx + 1'b1;
        if (st.is_echo) begin
          next_st.fsm = S_PRINT;
        end else if (st.fword < st.nw) begin
          if (st.fpos == FIELD_LAST) begin
            next_st.fpos  = 3'h0;
            next_st.fword = st.fword + 3'h1;
          end else begin
            next_st.fpos = st.fpos + 3'h1;
          end
        end else begin
          next_st.tail = st.tail + 2'h1;
          if (st.tail == TAIL_LAST) begin
            next_st.fsm = S_PRINT;
          end
        end
      end
      S_PRINT: begin
        // Buffer read is registered, so each character costs a fetch cycle
        if (st.fetched && tx_ready_in) begin
          next_st.fetched = 1'b0;
          next_st.ridx    = st.ridx + 1'b1;
          if (next_st.ridx == st.widx) begin
            next_st.fsm = st.ret;
          end
        end else begin
          next_st.fetched = 1'b1;
        end
      end
      S_CMD: begin
        if (rx_fire) begin
          if (rx_data_in == CH_LOAD || rx_data_in == CH_EXAM ||
              rx_data_in == CH_DEP || rx_data_in == CH_START) begin
            next_st.cmd = rx_data_in;
            next_st = start_line(next_st, NW_PROMPT, 1'b1, rx_data_in, S_SEP);
          end else if (is_alpha(rx_data_in)) begin
            next_st.dev_hi = rx_data_in;
            next_st = start_line(next_st, NW_PROMPT, 1'b1, rx_data_in, S_DEV);
          end else begin
            next_st = prompt(next_st);
          end
        end
      end
      S_DEV: begin
        if (rx_fire) begin
          if (is_alpha(rx_data_in)) begin
            next_st.boot_dev  = {st.dev_hi, rx_data_in};
            next_st.boot_unit = UNIT_DEFAULT;
            next_st.unit_seen = 1'b0;
            next_st = start_line(next_st, NW_PROMPT, 1'b1, rx_data_in, S_BOOT);
          end else begin
            next_st = prompt(next_st);
          end
        end
      end
      S_SEP: begin
        if (rx_fire) begin
          if (st.cmd == CH_START && (rx_data_in == CH_SP || rx_data_in == CH_CR)) begin
            next_st.start      = 1'b1;
            next_st.start_addr = st.addr;
            next_st.fsm        = S_EXIT;
          end else if (rx_data_in == CH_SP && st.cmd == CH_EXAM) begin
            adv_addr          = next_addr(st, OP_EXAM);
            next_st.addr      = adv_addr;
            next_st.mem_req   = 1'b1;
            next_st.mem_we    = 1'b0;
            next_st.mem_addr  = map_addr(adv_addr);
            next_st.fsm       = S_MEM;
          end else if (rx_data_in == CH_SP && st.cmd != CH_START) begin
            next_st.operand = 16'h0000;
            next_st = start_line(next_st, NW_PROMPT, 1'b1, CH_SP, S_OPND);
          end else begin
            next_st = prompt(next_st);
          end
        end
      end
      S_OPND: begin
        if (rx_fire) begin
          if (is_oct(rx_data_in)) begin
            next_st.operand = {st.operand[12:0], rx_data_in[2:0]};
            next_st = start_line(next_st, NW_PROMPT, 1'b1, rx_data_in, S_OPND);
          end else if (rx_data_in == CH_CR && st.cmd == CH_LOAD) begin
            next_st.addr    = st.operand;
            next_st.last_op = OP_LOAD;
            next_st = prompt(next_st);
          end else if (rx_data_in == CH_CR) begin
            adv_addr          = next_addr(st, OP_DEP);
            next_st.addr      = adv_addr;
            next_st.mem_req   = 1'b1;
            next_st.mem_we    = 1'b1;
            next_st.mem_addr  = map_addr(adv_addr);
            next_st.mem_wdata = st.operand;
            next_st.fsm       = S_MEM;
          end else begin
            next_st = prompt(next_st);
          end
        end
      end
      S_BOOT: begin
        if (rx_fire) begin
          if (rx_data_in == CH_CR) begin
            next_st.boot = 1'b1;
            next_st.fsm  = S_EXIT;
          end else if (is_oct(rx_data_in) && !st.unit_seen) begin
            next_st.boot_unit = rx_data_in[2:0];
            next_st.unit_seen = 1'b1;
            next_st = start_line(next_st, NW_PROMPT, 1'b1, rx_data_in, S_BOOT);
          end else begin
            next_st = prompt(next_st);
          end
        end
      end
      S_MEM: begin
        if (mem_ack_in) begin
          next_st.mem_req = 1'b0;
          if (st.mem_we) begin
            next_st.last_op = OP_DEP;
            next_st = prompt(next_st);
          end else begin
            next_st.last_op  = OP_EXAM;
            next_st.words[0] = st.addr;
            next_st.words[1] = mem_rdata_in;
            next_st = start_line(next_st, NW_EXAM, 1'b0, CH_SP, S_CMD);
          end
        end
      end
      S_EXIT: begin
        next_st.fsm = S_EXIT;
      end
      default: begin
        next_st.fsm = S_ENTRY;
      end
    endcase
    // Release of the switch wins over anything in progress
    if (st.bsync2 && !st.bprev) begin
      next_st.abort   = 1'b1;
      next_st.mem_req = 1'b0;
      next_st.start   = 1'b0;
      next_st.boot    = 1'b0;
      next_st.fsm     = S_ENTRY;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st        <= '0;
      st.fsm    <= S_ENTRY;
      st.ret    <= S_CMD;
      st.bsync1 <= 1'b1;
      st.bsync2 <= 1'b1;
      st.bprev  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  a_banner_start: assert property ((st.fsm == S_ENTRY) && diag_pass_in && !(st.bsync2 && !st.bprev)
    |=> st.fsm == S_FMT && st.nw == NW_BANNER && st.words[0] == $past(reg_r0_in))
    else $error("banner not started with four words");
  a_digit_shift: assert property ((st.fsm == S_OPND) && rx_fire && is_oct(rx_data_in) && !(st.bsync2 && !st.bprev)
    |=> st.operand == {$past(st.operand[12:0]), $past(rx_data_in[2:0])})
    else $error("operand digit not shifted in");
  a_bad_digit: assert property ((st.fsm == S_OPND) && rx_fire && !is_oct(rx_data_in)
    && rx_data_in != CH_CR |=> st.fsm != S_MEM && $stable(st.addr))
    else $error("bad digit did not abandon entry");
  a_load_store: assert property ((st.fsm == S_OPND) && rx_fire && rx_data_in == CH_CR && st.cmd == CH_LOAD
    |=> st.addr == $past(st.operand) && st.last_op == OP_LOAD)
    else $error("load did not store address");
  a_sep_error: assert property ((st.fsm == S_SEP) && rx_fire && rx_data_in != CH_SP && rx_data_in != CH_CR
    |=> $stable(st.addr) && !start_out && st.fsm != S_MEM)
    else $error("bad separator changed state");
  a_exam_step: assert property ((st.fsm == S_SEP) && rx_fire && rx_data_in == CH_SP && st.cmd == CH_EXAM
    && st.last_op == OP_EXAM && !(st.bsync2 && !st.bprev) |=> st.addr == $past(st.addr) + WORD_STEP)
    else $error("repeated examine did not advance");
  a_alt_hold: assert property ((st.fsm == S_SEP) && rx_fire && rx_data_in == CH_SP && st.cmd == CH_EXAM
    && st.last_op == OP_DEP |=> st.addr == $past(st.addr))
    else $error("alternating examine advanced address");
  a_io_map: assert property (mem_req_out |-> mem_addr_out[17:16] ==
    {2{&mem_addr_out[15:13]}} && mem_addr_out[15:0] == st.addr)
    else $error("address map wrong");
  a_dep_done: assert property (mem_req_out && mem_we_out && mem_ack_in && !(st.bsync2 && !st.bprev)
    |=> (st.fsm == S_FMT && st.nw == NW_PROMPT && !st.is_echo && wr_data == CH_CR) ##1 wr_data == CH_LF)
    else $error("deposit not followed by prompt");
  a_start_exit: assert property (start_out |-> !active_out && start_addr_out == st.addr)
    else $error("start did not leave interpreter");
  a_boot_abort: assert property (st.bsync2 && !st.bprev |=> abort_out && st.fsm == S_ENTRY)
    else $error("boot switch release not handled");
endmodule
`default_nettype wire

// file: tb/tci_terminal.sv
`timescale 1ns/1ps
`default_nettype none
module tci_terminal (
  input  wire logic       sys_clk_in,    // System clock
  input  wire logic       resetn_in,     // Async reset, active low
  input  wire logic       rx_ready_in,   // Key taken by the block
  input  wire logic       tx_valid_in,   // Printer character offered
  input  wire logic [7:0] tx_data_in,    // Printer character
  output logic            rx_valid_out,  // Key offered
  output logic      [7:0] rx_data_out,   // Key code
  output logic            tx_ready_out   // Printer accepts
);
  logic [7:0] keys[$];
  logic [7:0] paper[$];
  logic       slow;
  logic       took;
  int         tick;

  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b1;
    slow         = 1'b0;
    took         = 1'b0;
    tick         = 0;
  end

  always @(posedge sys_clk_in) begin
    took <= rx_valid_out & rx_ready_in;
    if (tx_valid_in && tx_ready_out) paper.push_back(tx_data_in);
  end

  // Idle key line toggles so a stale code is never mistaken for a key
  always @(negedge sys_clk_in) begin
    tick = tick + 1;
    if (took) void'(keys.pop_front());
    if (took || keys.size() == 0) begin
      rx_valid_out = 1'b0;
      rx_data_out  = ~rx_data_out;
    end else if (!rx_valid_out && resetn_in) begin
      rx_valid_out = 1'b1;
      rx_data_out  = keys[0];
    end
    tx_ready_out = !slow || tick[1];
  end
endmodule
`default_nettype wire

// file: tb/tci_console_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tci_console_tb;
  import tci_pkg::*;
  logic        sys_clk_in, resetn_in, boot_sw_n_in, diag_pass_in, rx_valid_in, rx_ready_out, tx_valid_out;
  logic        tx_ready_in, mem_req_out, mem_we_out, mem_ack_in, start_out, boot_out, abort_out, active_out;
  logic [15:0] reg_r0_in, reg_r4_in, reg_sp_in, reg_pc_in, mem_wdata_out, mem_rdata_in, start_addr_out;
  logic [15:0] boot_dev_out;
  logic [7:0]  rx_data_in, tx_data_out;
  logic [17:0] mem_addr_out, last_addr;
  logic [2:0]  boot_unit_out;
  logic [15:0] mem [logic [17:0]];
  logic [15:0] v [3] = '{16'h0200, 16'h0400, 16'h0B10};
  string       errs [5] = '{"L 79", "LX", "EX", "L 12\177", "7"};
  string       CR = "\015";
  string       PR = "\015\012$";
  string       BANNER = " 000001 177777 000500 100000\015\012$";
  int          err_count, n_tests, cyc, wcnt, mdly, n_start, n_boot, n_abort;

  tci_console u_dut (.sys_clk_in, .resetn_in, .boot_sw_n_in, .diag_pass_in, .reg_r0_in, .reg_r4_in, .reg_sp_in,
    .reg_pc_in, .rx_valid_in, .rx_data_in, .rx_ready_out, .tx_valid_out, .tx_data_out, .tx_ready_in,
    .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_rdata_in, .mem_ack_in, .start_out,
    .start_addr_out, .boot_out, .boot_dev_out, .boot_unit_out, .abort_out, .active_out);

  tci_terminal u_term (.sys_clk_in, .resetn_in, .rx_ready_in(rx_ready_out), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in), .tx_ready_out(tx_ready_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // Memory answers after mdly+1 cycles of req; guard stops a second ack while req drops
  always @(negedge sys_clk_in) begin
    mem_ack_in   = 1'b0;
    mem_rdata_in = ~mem_rdata_in;
    wcnt         = mem_req_out ? wcnt + 1 : 0;
    if (wcnt > mdly) begin
      mem_ack_in = 1'b1;
      wcnt       = -2;
      last_addr  = mem_addr_out;
      if (mem_we_out) mem[mem_addr_out] = mem_wdata_out;
      else mem_rdata_in = mem.exists(mem_addr_out) ? mem[mem_addr_out] : 16'h0000;
    end
  end

  always @(posedge sys_clk_in) begin
    cyc = cyc + 1;
    if (start_out === 1'b1) n_start++;
    if (boot_out === 1'b1) n_boot++;
    if (abort_out === 1'b1) n_abort++;
    if (cyc == 60000) begin
      err_count++;
      $display("unexpected %0t run too long", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [17:0] got, input logic [17:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Whole text, or only its tail where the echo of a bad key is open
  task automatic chk_txt(input string exp, input bit whole);
    int   off;
    logic bad;
    off = u_term.paper.size() - exp.len();
    bad = (off < 0) || (whole && off != 0);
    for (int i = 0; i < exp.len() && !bad; i++) if (u_term.paper[off + i] !== exp[i]) bad = 1'b1;
    n_tests++;
    if (bad) begin
      err_count++;
      $display("unexpected %0t printed text differs from %s", $time, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (rx_ready_out !== 1'b1 && n < 3000) begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask

  task automatic send(input string k);
    int n;
    u_term.paper.delete();
    foreach (k[i]) u_term.keys.push_back(k[i]);
    n = 0;
    while ((u_term.keys.size() > 0 || rx_ready_out !== 1'b1) && active_out === 1'b1 && n < 3000) begin
      @(negedge sys_clk_in);
      n++;
    end
    repeat (4) @(negedge sys_clk_in);
  endtask

  task automatic reboot();
    u_term.paper.delete();
    u_term.keys.delete();
    boot_sw_n_in = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    boot_sw_n_in = 1'b1;
    wait_ready();
    chk_txt(BANNER, 1'b1);
    chk_val(18'(n_abort), 18'(n_boot + n_start), "abort count");
  endtask

  task automatic t_load_exam();
    mem[18'h001C0] = 16'h0A5C;
    send({"L 700", CR});
    chk_txt({"L 700", PR}, 1'b1);
    send("E ");
    chk_txt({"E 000700 005134", PR}, 1'b1);
    chk_val(last_addr, 18'h001C0, "examine address");
    send("E ");
    chk_txt({"E 000702 000000", PR}, 1'b1);
  endtask

  task automatic t_deposits();
    u_term.slow = 1'b1;
    mdly        = 4;
    send({"L 500", CR});
    send({"D 60", CR});
    send({"D 2", CR});
    send({"D 4", CR});
    chk_txt({"D 4", PR}, 1'b1);
    chk_val({2'h0, mem[18'h00140]}, 18'h00030, "word 500");
    chk_val({2'h0, mem[18'h00142]}, 18'h00002, "word 502");
    chk_val({2'h0, mem[18'h00144]}, 18'h00004, "word 504");
    u_term.slow = 1'b0;
    mdly        = 1;
  endtask

  task automatic t_alternate();
    send({"L 500", CR});
    send("E ");
    chk_txt({"E 000500 000060", PR}, 1'b1);
    foreach (v[i]) begin
      send({"D ", $sformatf("%0o", v[i]), CR});
      send("E ");
      chk_txt({"E 000500 ", $sformatf("%06o", v[i]), PR}, 1'b1);
    end
  endtask

  task automatic t_errors();
    send({"L 600", CR});
    foreach (errs[i]) begin
      send(errs[i]);
      chk_txt(PR, 1'b0);
    end
    send("E ");
    chk_txt({"E 000600 000000", PR}, 1'b1);
    send({"L 1000502", CR});
    send("E ");
    chk_txt({"E 000502 000002", PR}, 1'b1);
    send({"L 177560", CR});
    send("E ");
    chk_val(last_addr, 18'h3FF70, "page address");
  endtask

  task automatic t_start();
    send({"L 1000", CR});
    send("S ");
    chk_val(18'(n_start), 18'h00001, "start pulses");
    chk_val({2'h0, start_addr_out}, 18'h00200, "start address");
    chk_val({17'h0, active_out}, 18'h00000, "owner after start");
    u_term.keys.push_back(CH_EXAM);
    repeat (60) @(negedge sys_clk_in);
    chk_val(18'(u_term.keys.size()), 18'h00001, "keys after exit");
  endtask

  task automatic t_boot(input string code, input logic [15:0] dev, input logic [2:0] unit);
    reboot();
    send({code, CR});
    chk_val({2'h0, boot_dev_out}, {2'h0, dev}, "boot device");
    chk_val({15'h0, boot_unit_out}, {15'h0, unit}, "boot unit");
    chk_val({17'h0, active_out}, 18'h00000, "owner after boot");
  endtask

  initial begin
    {err_count, n_tests, cyc, wcnt, n_start, n_boot, n_abort} = '0;
    mdly         = 1;
    resetn_in    = 1'b0;
    boot_sw_n_in = 1'b1;
    diag_pass_in = 1'b0;
    reg_r0_in    = 16'h0001;
    reg_r4_in    = 16'hFFFF;
    reg_sp_in    = 16'h0140;
    reg_pc_in    = 16'h8000;
    mem_ack_in   = 1'b0;
    mem_rdata_in = 16'h0000;
    last_addr    = 18'h00000;
    repeat (16) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    diag_pass_in = 1'b1;
    wait_ready();
    chk_txt(BANNER, 1'b1);
    t_load_exam();
    t_deposits();
    t_alternate();
    t_errors();
    t_start();
    t_boot("XY", 16'h5859, 3'h0);
    t_boot("PR5", 16'h5052, 3'h5);
    chk_val(18'(n_boot), 18'h00002, "boot pulses");
    close_out();
  end
endmodule
`default_nettype wire
